//--- core/exv_regs.svh
// Register offsets, reset values and vector addresses of the vector/priority block
`ifndef EXV_REGS_SVH
`define EXV_REGS_SVH
`define EXV_OFF_CORE 12'h000
`define EXV_OFF_STATUS 12'h004
`define EXV_OFF_INTCTL 12'h008
`define EXV_OFF_WINNER 12'h00c
`define EXV_OFF_PRIO_BASE 12'h100
`define EXV_OFF_PRIO_END 12'h2d8
`define EXV_PRIO_IDX_BASE 8'h40
`define EXV_CORE_RESET 16'h0020
`define EXV_CORE_WMASK 16'h18f7
`define EXV_PRIORITY_LEVEL_MSB_MASK 16'h0008
`define EXV_PRIORITY_LEVEL_MSB_BIT 3
`define EXV_NEST_BIT 15
`define EXV_ALT_BIT 0
`define EXV_RESET_ADDR 24'h000000
`define EXV_RESET_TARGET 24'h000002
`define EXV_TRAP_BASE 24'h000006
`define EXV_IRQ_BASE 24'h000014
`define EXV_IRQ_LAST_ADDR 24'h0000fe
`define EXV_ALT_OFFSET 24'h000100
`define EXV_ALT_IRQ_BASE 24'h000114
`define EXV_ALT_LAST_ADDR 24'h0001fe
`define EXV_NUM_IRQ 118
`define EXV_LAST_IRQ 7'h75
`define EXV_NUM_TRAP 4
`endif

//--- core/exv_pkg.sv
// Types shared by the vector/priority block
package exv_pkg;
   typedef enum logic [2:0] {
      EXV_K_RESET = 3'b001,
      EXV_K_TRAP = 3'b010,
      EXV_K_IRQ = 3'b100
   } exv_kind_t;
   typedef enum logic [2:0] {
      EXV_S_IDLE = 3'b001,
      EXV_S_WAIT = 3'b010,
      EXV_S_ANS = 3'b100
   } exv_apb_st_t;
   typedef struct packed {
      logic valid;
      logic [6:0] num;
      logic [2:0] prio;
   } exv_cand_t;
   typedef struct packed {
      logic valid;
      exv_kind_t kind;
      logic [6:0] index;
      logic [2:0] prio;
      logic [23:0] addr;
   } exv_take_t;
endpackage

//--- core/exv_prio_mem.sv
// Per-source priority table, one write port and two registered read ports
`timescale 1ns/1ps
module exv_prio_mem (
   input wire logic sys_clk,
   input wire logic wr_en,
   input wire logic [6:0] wr_addr,
   input wire logic [2:0] wr_data,
   input wire logic [6:0] rd_a_addr,
   output logic [2:0] rd_a_data,
   input wire logic [6:0] rd_b_addr,
   output logic [2:0] rd_b_data
);
   logic [2:0] mem [0:127];

   // Contents are undefined until software programs them
   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule // exv_prio_mem

//--- core/exv_vec_map.sv
// Maps a vector kind and index to its program-memory address
`timescale 1ns/1ps
`include "exv_regs.svh"
module exv_vec_map (
   input exv_pkg::exv_kind_t kind,
   input wire logic [6:0] index,
   input wire logic alt,
   output logic [23:0] addr
);
   wire [23:0] step = {16'h0000, index, 1'b0};
   wire [23:0] alt_add = alt ? `EXV_ALT_OFFSET : 24'h000000;
   wire [23:0] trap_addr = `EXV_TRAP_BASE + step + alt_add; // R2
   wire [23:0] irq_addr = `EXV_IRQ_BASE + step + alt_add; // R3 R9

   // Reset always jumps from the lowest word
   assign addr = (kind == exv_pkg::EXV_K_TRAP) ? trap_addr :
                 (kind == exv_pkg::EXV_K_IRQ) ? irq_addr : `EXV_RESET_ADDR; // R1
endmodule // exv_vec_map

//--- core/exv_core.sv
// Exception vector selection, priority arbitration and core control register
//
// What this block does
// R1 - Reset starts at word zero, target follows
// R2 - Reserved word, then four traps, three reserved
// R3 - Interrupt vectors from 0x14, one per word
// R4 - Vector 117 at 0xFE, next word reserved
// R5 - Priority level is msb bit over status bits
// R6 - Control resets 0x0020; msb bit only software-cleared
// R7 - Msb bit set means level above seven
// R8 - Msb bit set blocks all user interrupts
// R9 - Alternate table vectors 0x114 to 0x1FE
// R10 - Nesting disable blocks software writes to status priority bits; a taken interrupt still loads them
// R11 - Equal priority: lower vector number wins
`timescale 1ns/1ps
`include "exv_regs.svh"
module exv_core (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] trap_req,
   input wire logic [117:0] irq_pending,
   input wire logic cpu_ack,
   output exv_pkg::exv_take_t take,
   output logic [3:0] cpu_priority_level,
   output logic user_irq_blocked,
   output logic [15:0] core_control
);
   ////////////////////////////////////////////////////////////////////////////
   // Register state
   exv_pkg::exv_apb_st_t st_reg;
   exv_pkg::exv_apb_st_t st_next;
   logic [15:0] core_reg;
   logic [15:0] core_next;
   logic [2:0] ipl_lo_reg;
   logic [2:0] ipl_lo_next;
   logic nest_reg;
   logic alt_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   exv_pkg::exv_take_t take_reg;
   exv_pkg::exv_take_t take_next;
   exv_pkg::exv_cand_t cand_reg;
   exv_pkg::exv_cand_t best_reg;
   exv_pkg::exv_cand_t best_next;
   logic [6:0] scan_idx_reg;
   logic [6:0] scan_idx_d_reg;
   logic scan_live_reg;
   logic [117:0] pend_snap_reg;
   logic [2:0] bus_prio;
   logic [2:0] scan_prio;
   logic [23:0] map_addr;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode
   wire aligned = (paddr[1:0] == 2'b00);
   wire dec_core = (paddr == `EXV_OFF_CORE);
   wire dec_status = (paddr == `EXV_OFF_STATUS);
   wire dec_intctl = (paddr == `EXV_OFF_INTCTL);
   wire dec_winner = (paddr == `EXV_OFF_WINNER);
   wire dec_prio = aligned && (paddr >= `EXV_OFF_PRIO_BASE) && (paddr < `EXV_OFF_PRIO_END);
   wire dec_hit = dec_core || dec_status || dec_intctl || dec_winner || dec_prio;
   wire [7:0] prio_idx8 = paddr[9:2] - `EXV_PRIO_IDX_BASE;
   wire [6:0] prio_idx = prio_idx8[6:0];
   wire setup = psel && !penable;
   wire wr_fire = (st_reg == exv_pkg::EXV_S_ANS) && psel && penable && pwrite && dec_hit;
   wire prio_wr = wr_fire && dec_prio;

   wire [31:0] rd_core = {16'h0000, core_reg};
   wire [31:0] rd_status = {24'h000000, ipl_lo_reg, 5'b00000};
   wire [31:0] rd_intctl = {16'h0000, nest_reg, 14'h0000, alt_reg};
   wire [31:0] rd_winner = {16'h0000, cand_reg.valid, 4'h0, cand_reg.prio, 1'b0, cand_reg.num};
   wire [31:0] rd_prio = {29'h00000000, bus_prio};
   wire [31:0] rd_mux = dec_core ? rd_core :
                        dec_status ? rd_status :
                        dec_intctl ? rd_intctl :
                        dec_winner ? rd_winner :
                        dec_prio ? rd_prio : 32'h00000000;

   // Every access answers in the second access cycle, the table read needs one
   always_comb begin
      case (st_reg)
         exv_pkg::EXV_S_IDLE: st_next = setup ? exv_pkg::EXV_S_WAIT : exv_pkg::EXV_S_IDLE;
         exv_pkg::EXV_S_WAIT: st_next = penable ? exv_pkg::EXV_S_ANS : exv_pkg::EXV_S_WAIT;
         exv_pkg::EXV_S_ANS: st_next = exv_pkg::EXV_S_IDLE;
         default: st_next = exv_pkg::EXV_S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= exv_pkg::EXV_S_IDLE;
         prdata_reg <= 32'h00000000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         pready_reg <= (st_reg == exv_pkg::EXV_S_WAIT) && penable;
         pslverr_reg <= (st_reg == exv_pkg::EXV_S_WAIT) && penable && !dec_hit;
         if ((st_reg == exv_pkg::EXV_S_WAIT) && penable) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority table and sweep arbiter
   exv_prio_mem u_mem (
      .sys_clk(sys_clk),
      .wr_en(prio_wr),
      .wr_addr(prio_idx),
      .wr_data(pwdata[2:0]),
      .rd_a_addr(prio_idx),
      .rd_a_data(bus_prio),
      .rd_b_addr(scan_idx_reg),
      .rd_b_data(scan_prio)
   );

   wire scan_last = (scan_idx_reg == `EXV_LAST_IRQ);
   wire sweep_end = scan_live_reg && (scan_idx_d_reg == `EXV_LAST_IRQ);
   // Pending set frozen per sweep, else a late low vector loses to a higher one
   // Strictly greater: an equal later vector never displaces the earlier one
   wire scan_win = scan_live_reg && pend_snap_reg[scan_idx_d_reg] &&
                   (scan_prio > best_reg.prio); // R11
   wire irq_ack = take_reg.valid && cpu_ack && (take_reg.kind == exv_pkg::EXV_K_IRQ);
   wire trap_ack = take_reg.valid && cpu_ack && (take_reg.kind == exv_pkg::EXV_K_TRAP);

   assign best_next = scan_win ? '{valid: 1'b1, num: scan_idx_d_reg, prio: scan_prio}
                               : best_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         scan_idx_reg <= 7'h00;
         scan_idx_d_reg <= 7'h00;
         scan_live_reg <= 1'b0;
         best_reg <= '0;
         cand_reg <= '0;
         pend_snap_reg <= '0;
      end else begin
         scan_idx_reg <= scan_last ? 7'h00 : scan_idx_reg + 7'h01;
         scan_idx_d_reg <= scan_idx_reg;
         scan_live_reg <= 1'b1;
         best_reg <= sweep_end ? '0 : best_next;
         if (sweep_end) begin
            cand_reg <= best_next;
            pend_snap_reg <= irq_pending; // R11
         end else if (irq_ack) begin
            cand_reg.valid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Core control, status priority bits and nesting control
   wire [3:0] ipl = {core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT], ipl_lo_reg}; // R5
   wire priority_level_msb_set = trap_ack;
   wire core_wr = wr_fire && dec_core;
   // Write of one to the msb bit has no effect, zero clears it
   wire [15:0] core_wr_val = (pwdata[15:0] & `EXV_CORE_WMASK) |
                             (core_reg & pwdata[15:0] & `EXV_PRIORITY_LEVEL_MSB_MASK); // R6
   // Hardware set wins over a same-cycle software clear
   assign core_next = (core_wr ? core_wr_val : core_reg) |
                      (priority_level_msb_set ? `EXV_PRIORITY_LEVEL_MSB_MASK : 16'h0000); // R6
   wire status_wr = wr_fire && dec_status && !nest_reg; // R10
   assign ipl_lo_next = irq_ack ? take_reg.prio :
                        status_wr ? pwdata[7:5] : ipl_lo_reg;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         core_reg <= `EXV_CORE_RESET; // R6
         ipl_lo_reg <= 3'h0;
         nest_reg <= 1'b0;
         alt_reg <= 1'b0;
      end else begin
         core_reg <= core_next;
         ipl_lo_reg <= ipl_lo_next;
         if (wr_fire && dec_intctl) begin
            nest_reg <= pwdata[`EXV_NEST_BIT];
            alt_reg <= pwdata[`EXV_ALT_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Vector offer to the CPU
   wire trap_any = |trap_req;
   wire [6:0] trap_idx = trap_req[0] ? 7'h00 :
                         trap_req[1] ? 7'h01 :
                         trap_req[2] ? 7'h02 : 7'h03; // R2
   // Level above seven, so no three-bit source priority can exceed it
   wire irq_ok = cand_reg.valid && irq_pending[cand_reg.num] &&
                 !core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT] && ({1'b0, cand_reg.prio} > ipl); // R7 R8
   wire offer_trap = !take_reg.valid && trap_any;
   wire offer_irq = !take_reg.valid && !trap_any && irq_ok;
   wire exv_pkg::exv_kind_t offer_kind = offer_trap ? exv_pkg::EXV_K_TRAP
                                                    : exv_pkg::EXV_K_IRQ;
   wire [6:0] offer_idx = offer_trap ? trap_idx : cand_reg.num;

   exv_vec_map u_map (
      .kind(offer_kind),
      .index(offer_idx),
      .alt(alt_reg),
      .addr(map_addr)
   );

   always_comb begin
      take_next = take_reg;
      if (take_reg.valid && cpu_ack) begin
         take_next.valid = 1'b0;
      end else if (offer_trap || offer_irq) begin
         take_next.valid = 1'b1;
         take_next.kind = offer_kind;
         take_next.index = offer_idx;
         take_next.prio = offer_trap ? 3'h7 : cand_reg.prio;
         take_next.addr = map_addr; // R3 R4 R9
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         take_reg <= '{valid: 1'b1, kind: exv_pkg::EXV_K_RESET, index: 7'h00,
                       prio: 3'h0, addr: `EXV_RESET_ADDR}; // R1
      end else begin
         take_reg <= take_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign take = take_reg;
   assign cpu_priority_level = ipl;
   assign user_irq_blocked = core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT];
   assign core_control = core_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   AST_RESET_VEC: assert property ($rose(rstn) |-> take_reg.valid && // R1
      take_reg.kind == exv_pkg::EXV_K_RESET && take_reg.addr == `EXV_RESET_ADDR)
      else $error("reset vector not offered at word zero");
   AST_TRAP_ADDR: assert property (take_reg.valid && // R2
      take_reg.kind == exv_pkg::EXV_K_TRAP && !alt_reg |->
      take_reg.addr == `EXV_TRAP_BASE + {16'h0000, take_reg.index, 1'b0} &&
      take_reg.index < 7'h04)
      else $error("trap vector address wrong");
   AST_IRQ_RANGE: assert property (take_reg.valid && // R3
      take_reg.kind == exv_pkg::EXV_K_IRQ && !alt_reg |->
      take_reg.addr >= `EXV_IRQ_BASE && take_reg.addr <= `EXV_IRQ_LAST_ADDR)
      else $error("primary interrupt vector outside table");
   AST_LAST_VEC: assert property (take_reg.valid && take_reg.index == `EXV_LAST_IRQ && // R4
      take_reg.kind == exv_pkg::EXV_K_IRQ && !alt_reg |-> take_reg.addr == `EXV_IRQ_LAST_ADDR)
      else $error("vector 117 address wrong");
   AST_ALT_RANGE: assert property (take_reg.valid && // R9
      take_reg.kind == exv_pkg::EXV_K_IRQ && alt_reg |->
      take_reg.addr >= `EXV_ALT_IRQ_BASE && take_reg.addr <= `EXV_ALT_LAST_ADDR)
      else $error("alternate interrupt vector outside table");
   AST_IPL_TAKE: assert property (irq_ack |=> // R5
      cpu_priority_level == {$past(core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT]), $past(take_reg.prio)})
      else $error("priority level not formed from taken interrupt");
   AST_CORE_RESET: assert property ($rose(rstn) |-> core_reg == `EXV_CORE_RESET) // R6
      else $error("core control reset value wrong");
   AST_PRIORITY_LEVEL_MSB_NOSET: assert property (!core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT] && !trap_ack |=> // R6
      !core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT])
      else $error("msb priority bit set without a trap");
   AST_BLOCK_USER: assert property ($rose(take_reg.valid) && // R7
      take_reg.kind == exv_pkg::EXV_K_IRQ |->
      !$past(core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT]) && {1'b0, take_reg.prio} > $past(ipl)) // R8
      else $error("user interrupt offered at or above its level");
   AST_NEST_RO: assert property (wr_fire && dec_status && nest_reg && !irq_ack |=> // R10
      $stable(ipl_lo_reg))
      else $error("status priority bits written while nesting disabled");
   AST_APB_ANS: assert property (setup ##1 (psel && penable) |-> ##1 pready ##1 !pready)
      else $error("apb answer not in second access cycle");
   AST_ERR_READ: assert property (pslverr |-> pready && prdata == 32'h00000000)
      else $error("error answer without ready or with data");
   AST_TAKE_HOLD: assert property (take_reg.valid && !cpu_ack |=> $stable(take_reg)) // R1
      else $error("vector offer changed before the cpu took it");
   AST_ACK_DROP: assert property (take_reg.valid && cpu_ack |=> !take_reg.valid) // R1
      else $error("vector offer still valid after ack");
   AST_TRAP_LEVEL: assert property (trap_ack |=> core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT]) // R7
      else $error("taken trap did not raise the level above seven");
   AST_TRAP_FIRST: assert property (!take_reg.valid && trap_req != 4'h0 |=> // R8
      take_reg.valid && take_reg.kind == exv_pkg::EXV_K_TRAP)
      else $error("pending trap not offered");

   COV_TRAP: cover property (trap_ack);
   COV_IRQ: cover property (irq_ack ##[1:20] trap_ack);
   COV_EQUAL: cover property (sweep_end && best_reg.valid && scan_live_reg &&
      pend_snap_reg[scan_idx_d_reg] && scan_prio == best_reg.prio); // R11
   COV_PRIORITY_LEVEL_MSB_CLR: cover property (core_wr && core_reg[`EXV_PRIORITY_LEVEL_MSB_BIT] && !pwdata[3]);
endmodule // exv_core

//--- test/exv_cpu_model.sv
// CPU core model that accepts vector offers after a set delay
`timescale 1ns/1ps
module exv_cpu_model (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire exv_pkg::exv_take_t take,
   input wire logic [3:0] ack_delay,
   output logic cpu_ack
);
   logic [3:0] wait_cnt;
   ////////////////////////////////////////////////////////////////////////////////
   // Ack is a one-cycle pulse, then the model waits for the next offer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (cpu_ack) begin
         cpu_ack <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (take.valid === 1'b1) begin
         if (wait_cnt >= ack_delay) begin
            cpu_ack <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule // exv_cpu_model

//--- test/exv_core_test.sv
// Self-checking bench for the vector and priority block
`timescale 1ns/1ps
module exv_core_test;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] trap_req = 4'h0;
   logic [117:0] irq_pending = '0;
   logic cpu_ack;
   logic [3:0] ack_delay = 4'h0;
   exv_pkg::exv_take_t take;
   exv_pkg::exv_take_t got;
   logic [3:0] cpu_priority_level;
   logic user_irq_blocked;
   logic [15:0] core_control;
   logic [31:0] rd;
   logic err;
   int bad_count = 0;
   int n_tests = 0;
   int v;
   int seed_val;
   int lvl_q[$];
   always #12.5 sys_clk = ~sys_clk;
   exv_core u_exv_core (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trap_req(trap_req), .irq_pending(irq_pending), .cpu_ack(cpu_ack),
      .take(take), .cpu_priority_level(cpu_priority_level),
      .user_irq_blocked(user_irq_blocked), .core_control(core_control));
   exv_cpu_model u_exv_cpu_model (.sys_clk(sys_clk), .rstn(rstn), .take(take),
      .ack_delay(ack_delay), .cpu_ack(cpu_ack));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      n_tests++;
      if (got_v !== exp_v) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got_v, exp_v);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge sys_clk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(n < 20), 32'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Captures the offer at the edge where the model's ack is sampled
   task automatic wait_take(input int lim);
      int n;
      n = 0;
      @(posedge sys_clk);
      while (cpu_ack !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(n < lim), 32'h1);
      got = take;
   endtask
   function automatic logic [23:0] exp_addr(input int is_irq, input int idx, input int alt);
      int a;
      a = (is_irq != 0 ? 'h14 : 'h6) + 2 * idx + (alt != 0 ? 'h100 : 0);
      return 24'(a);
   endfunction
   task automatic chk_take(input int is_irq, input int idx, input int pr, input int alt);
      wait_take(600);
      chk(32'(got.kind), is_irq != 0 ? 32'h4 : 32'h2);
      chk(32'(got.index), 32'(idx));
      chk(32'(got.prio), 32'(pr));
      chk(32'(got.addr), 32'(exp_addr(is_irq, idx, alt)));
   endtask
   task automatic irq_case(input int vec, input int pr, input int alt);
      apb(1'b1, 12'h100 + 12'(4 * vec), 32'(pr));
      apb(1'b1, 12'h004, 32'h0);
      irq_pending[vec] <= 1'b1;
      chk_take(1, vec, pr, alt);
      lvl_q.push_back(pr);
      irq_pending[vec] <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(32'(cpu_priority_level), 32'(lvl_q[0]));
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'(lvl_q.pop_front()) << 5);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 40000);
      bad_count++;
      summarize();
   end
   initial begin
      seed_val = $urandom(32'h8f45);
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      chk(32'(core_control), 32'h20);
      chk(32'(cpu_priority_level), 32'h0);
      wait_take(20);
      chk(32'(got.kind), 32'h1);
      chk(32'(got.addr), 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h20);
      apb(1'b1, 12'h000, 32'hffff);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h18f7);
      apb(1'b1, 12'h000, 32'h20);
      apb(1'b0, 12'h010, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         ack_delay <= 4'(i);
         trap_req <= 4'h1 << i;
         chk_take(0, i, 7, 0);
         trap_req <= 4'h0;
         repeat (2) @(posedge sys_clk);
         chk({30'h0, cpu_priority_level[3], user_irq_blocked}, 32'h3);
         if (i == 0) begin
            apb(1'b1, 12'h114, 32'h7);
            irq_pending[5] <= 1'b1;
            v = 0;
            repeat (300) begin
               @(posedge sys_clk);
               v += int'(take.valid === 1'b1);
            end
            chk(32'(v), 32'h0);
            apb(1'b1, 12'h000, 32'h20);
            chk_take(1, 5, 7, 0);
            irq_pending[5] <= 1'b0;
         end
         apb(1'b1, 12'h000, 32'h20);
         repeat (2) @(posedge sys_clk);
         chk({30'h0, cpu_priority_level[3], user_irq_blocked}, 32'h0);
      end
      trap_req <= 4'hc;
      chk_take(0, 2, 7, 0);
      trap_req <= 4'h8;
      chk_take(0, 3, 7, 0);
      trap_req <= 4'h0;
      apb(1'b1, 12'h000, 32'h20);
      irq_case(117, 1 + int'($urandom % 7), 0);
      irq_case(0, 1 + int'($urandom % 7), 0);
      for (int k = 0; k < 4; k++) begin
         irq_case(int'($urandom % 118), 1 + int'($urandom % 7), 0);
      end
      apb(1'b1, 12'h128, 32'h4);
      apb(1'b1, 12'h150, 32'h4);
      apb(1'b1, 12'h004, 32'h0);
      irq_pending[10] <= 1'b1;
      irq_pending[20] <= 1'b1;
      chk_take(1, 10, 4, 0);
      irq_pending[10] <= 1'b0;
      irq_pending[20] <= 1'b0;
      apb(1'b1, 12'h008, 32'h1);
      irq_case(117, 3, 1);
      trap_req <= 4'h1;
      chk_take(0, 0, 7, 1);
      trap_req <= 4'h0;
      apb(1'b1, 12'h004, 32'h20);
      apb(1'b1, 12'h008, 32'h8000);
      apb(1'b1, 12'h004, 32'he0);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h20);
      summarize();
   end
endmodule // exv_core_test
